// ===== src/adc_win_pkg.sv
// Purpose: Shared constants for the converter result and window register block.
// Assumes: Register indices are byte-register numbers; the bus address is four times the index.
// Notes:   Each figure appears here once.
package adc_win_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  localparam int          SAMPLE_W        = 10;
  localparam int          RESULT_W        = 16;
  localparam int          MAX_ACCUM       = 64;
  // Register indices.
  localparam logic [5:0]  IDX_WIN_MODE    = 6'h04;
  localparam logic [5:0]  IDX_IRQ_ENABLE  = 6'h0A;
  localparam logic [5:0]  IDX_IRQ_FLAGS   = 6'h0B;
  localparam logic [5:0]  IDX_DEBUG_CTRL  = 6'h0C;
  localparam logic [5:0]  IDX_STAGING     = 6'h0D;
  localparam logic [5:0]  IDX_RESULT      = 6'h10;
  localparam logic [5:0]  IDX_WIN_LOWER   = 6'h12;
  localparam logic [5:0]  IDX_WIN_UPPER   = 6'h14;
  localparam logic [5:0]  IDX_CLK_CONVERTER_CLOCK_CALIBRATION   = 6'h16;
  localparam logic [5:0]  IDX_IRQ_CLEAR   = 6'h18;
  // Field positions.
  localparam int          BIT_DEBUG_CONT  = 0;
  localparam int          BIT_CLK_DUTY    = 0;
  localparam int          BIT_FLAG_READY  = 0;
  localparam int          BIT_FLAG_MATCH  = 1;
  // Reset values and sample saturation limits.
  localparam logic [7:0]  RST_DEBUG_CTRL  = 8'h00;
  localparam logic [7:0]  RST_STAGING     = 8'h00;
  localparam logic [15:0] RST_RESULT      = 16'h0000;
  localparam logic [15:0] RST_WIN_LIMIT   = 16'h0000;
  localparam logic [7:0]  RST_CLK_CONVERTER_CLOCK_CALIBRATION   = 8'h01;
  localparam logic [2:0]  RST_WIN_MODE    = 3'h0;
  localparam logic [9:0]  SAMPLE_MAX      = 10'h3FF;
  localparam logic [9:0]  SAMPLE_MIN      = 10'h000;
  // Window comparison modes.
  localparam logic [2:0]  WIN_NONE        = 3'h0;
  localparam logic [2:0]  WIN_BELOW       = 3'h1;
  localparam logic [2:0]  WIN_ABOVE       = 3'h2;
  localparam logic [2:0]  WIN_INSIDE      = 3'h3;
  localparam logic [2:0]  WIN_OUTSIDE     = 3'h4;
endpackage

// ===== src/accum_if.sv
// Purpose: Carrier between the register front end and the accumulator.
// Assumes: One clock; all signals are synchronous to it.
// Notes:   Front end drives samples and settings, accumulator returns the result.
`timescale 1ns/1ps
interface accum_if;
  logic        sample_valid;
  logic [9:0]  sample;
  logic        over_range;
  logic        under_range;
  logic        last;
  logic [2:0]  win_mode;
  logic [15:0] win_lower;
  logic [15:0] win_upper;
  logic        done;
  logic        match;
  logic [15:0] result;
  modport front (output sample_valid, sample, over_range, under_range, last,
                 win_mode, win_lower, win_upper, input done, match, result);
  modport accum (input sample_valid, sample, over_range, under_range, last,
                 win_mode, win_lower, win_upper, output done, match, result);
endinterface

// ===== src/adc_accum_window.sv
// Purpose: Saturates samples, accumulates them and compares the total with the window.
// Assumes: The last sample of a burst is flagged by last together with sample_valid.
// Notes:   done and match are one-cycle pulses at the end of a burst.
`timescale 1ns/1ps
module adc_accum_window
  import adc_win_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  accum_if.accum    acc
);
  logic [15:0] sum_r;
  logic [15:0] sum_nxt;
  logic [15:0] result_r;
  logic [15:0] result_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        match_r;
  logic        match_nxt;
  logic [9:0]  value;
  logic [15:0] total;
  logic        below;
  logic        above;

  always_comb
  begin
    value = acc.sample;
    if (acc.over_range)
    begin
      value = SAMPLE_MAX;
    end
    else if (acc.under_range)
    begin
      value = SAMPLE_MIN;
    end
    // Sixty-four full-scale samples peak at 0xFFC0, so sixteen bits do not wrap in bursts of up to sixty-four samples.
    total      = sum_r + {6'h00, value};
    below      = total < acc.win_lower;
    above      = total > acc.win_upper;
    sum_nxt    = sum_r;
    result_nxt = result_r;
    done_nxt   = 1'b0;
    match_nxt  = 1'b0;
    if (acc.sample_valid)
    begin
      sum_nxt = total;
      if (acc.last)
      begin
        sum_nxt    = 16'h0000;
        result_nxt = total;
        done_nxt   = 1'b1;
        // The total, not each sample, meets the window.
        case (acc.win_mode)
          WIN_BELOW:   match_nxt = below;
          WIN_ABOVE:   match_nxt = above;
          WIN_INSIDE:  match_nxt = (total > acc.win_lower) && (total < acc.win_upper);
          WIN_OUTSIDE: match_nxt = below || above;
          default:     match_nxt = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sum_r    <= 16'h0000;
      result_r <= RST_RESULT;
      done_r   <= 1'b0;
      match_r  <= 1'b0;
    end
    else
    begin
      sum_r    <= sum_nxt;
      result_r <= result_nxt;
      done_r   <= done_nxt;
      match_r  <= match_nxt;
    end
  end

  assign acc.result = result_r;
  assign acc.done   = done_r;
  assign acc.match  = match_r;
endmodule

// ===== src/adc_result_window_regs.sv
// Purpose: Register front end of the converter result, window and clock duty settings.
// Assumes: APB slave; sample inputs and debug halt come from logic on REF_CLK.
// Notes:   Each byte register sits in one word at four times its index.
// How it works
// - With debug_continue low, halt and drop events and samples during debug.
// - One byte_staging register, read and write, serves all 16-bit registers.
// - conversion_result is read only; low byte at base, high byte at base plus one.
// - Over-range samples read 0x3FF, under-range samples read 0x000.
// - Accumulator is sixteen bits; sixty-four full samples stay within 0xFFC0.
// - Results are unsigned; a single sample sits in bits 9 to 0.
// - Window comparison uses the final accumulated total, not each sample.
// - window_lower_limit is 16-bit read-write at 0x12 and 0x13, resets zero.
// - window_upper_limit is 16-bit read-write at 0x14 and 0x15, resets zero.
// - converter_clock_duty picks 50 or 25 percent duty, resetting to 25.
// - window_compare_select picks none, below, above, inside or outside.
// - Reading the result or writing ones clears result_ready and window_match flags.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module adc_result_window_regs
  import adc_win_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [DATA_W-1:0] PWDATA,
  output logic      [DATA_W-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              SAMPLE_VALID,
  input  wire logic [9:0]        SAMPLE_DATA,
  input  wire logic              SAMPLE_OVER,
  input  wire logic              SAMPLE_UNDER,
  input  wire logic              SAMPLE_LAST,
  input  wire logic              DEBUG_HALT,
  input  wire logic              EVENT_IN,
  output logic                   EVENT_ACCEPT,
  output logic                   CONV_HALT,
  output logic                   CLK_DUTY_25,
  output logic                   RESULT_READY,
  output logic                   WINDOW_MATCH,
  output logic                   IRQ
);
  accum_if     acc ();
  logic        rst_meta_r;
  logic        rst_n;
  logic [7:0]  debug_ctrl_r;
  logic [7:0]  debug_ctrl_nxt;
  logic [7:0]  staging_r;
  logic [7:0]  staging_nxt;
  logic [15:0] win_lower_r;
  logic [15:0] win_lower_nxt;
  logic [15:0] win_upper_r;
  logic [15:0] win_upper_nxt;
  logic [7:0]  converter_clock_calibration_r;
  logic [7:0]  converter_clock_calibration_nxt;
  logic [2:0]  win_mode_r;
  logic [2:0]  win_mode_nxt;
  logic [1:0]  irq_en_r;
  logic [1:0]  irq_en_nxt;
  logic [1:0]  flags_r;
  logic [1:0]  flags_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic        evt_nxt;
  logic        halt_nxt;
  logic        halted;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;
  logic [7:0]  wbyte;
  logic [1:0]  clr;
  logic        mapped;

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  assign halted           = DEBUG_HALT && !debug_ctrl_r[BIT_DEBUG_CONT];
  assign acc.sample_valid = SAMPLE_VALID && !halted;
  assign acc.sample       = SAMPLE_DATA;
  assign acc.over_range   = SAMPLE_OVER;
  assign acc.under_range  = SAMPLE_UNDER;
  assign acc.last         = SAMPLE_LAST;
  assign acc.win_mode     = win_mode_r;
  assign acc.win_lower    = win_lower_r;
  assign acc.win_upper    = win_upper_r;

  adc_accum_window u_accum (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .acc   (acc)
  );

  assign idx   = PADDR[7:2];
  assign wbyte = PWDATA[7:0];
  assign wr    = PSEL && PENABLE && PREADY && PWRITE;
  assign rd    = PSEL && PENABLE && PREADY && !PWRITE;

  always_comb
  begin
    case (idx)
      IDX_WIN_MODE, IDX_IRQ_ENABLE, IDX_IRQ_FLAGS, IDX_DEBUG_CTRL, IDX_STAGING,
      IDX_RESULT, IDX_RESULT + 6'h01, IDX_WIN_LOWER, IDX_WIN_LOWER + 6'h01,
      IDX_WIN_UPPER, IDX_WIN_UPPER + 6'h01, IDX_CLK_CONVERTER_CLOCK_CALIBRATION, IDX_IRQ_CLEAR:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // Each access completes in the first cycle of its access phase, with no wait; read data is set up in the setup phase.
  always_comb
  begin
    pready_nxt  = PSEL && !PENABLE;
    pslverr_nxt = PSEL && !PENABLE && !mapped;
    prdata_nxt  = PRDATA;
    if (PSEL && !PENABLE)
    begin
      prdata_nxt = 32'h0000_0000;
      case (idx)
        IDX_WIN_MODE:              prdata_nxt[2:0] = win_mode_r;
        IDX_IRQ_ENABLE:            prdata_nxt[1:0] = irq_en_r;
        IDX_IRQ_FLAGS:             prdata_nxt[1:0] = flags_r;
        IDX_DEBUG_CTRL:            prdata_nxt[7:0] = debug_ctrl_r;
        IDX_STAGING:               prdata_nxt[7:0] = staging_r;
        IDX_RESULT:                prdata_nxt[7:0] = acc.result[7:0];
        IDX_WIN_LOWER:             prdata_nxt[7:0] = win_lower_r[7:0];
        IDX_WIN_UPPER:             prdata_nxt[7:0] = win_upper_r[7:0];
        IDX_CLK_CONVERTER_CLOCK_CALIBRATION:             prdata_nxt[7:0] = converter_clock_calibration_r;
        // High bytes of 16-bit registers return the byte staged by the low read.
        IDX_RESULT + 6'h01,
        IDX_WIN_LOWER + 6'h01,
        IDX_WIN_UPPER + 6'h01:     prdata_nxt[7:0] = staging_r;
        default:                   prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    debug_ctrl_nxt = debug_ctrl_r;
    staging_nxt    = staging_r;
    win_lower_nxt  = win_lower_r;
    win_upper_nxt  = win_upper_r;
    converter_clock_calibration_nxt      = converter_clock_calibration_r;
    win_mode_nxt   = win_mode_r;
    irq_en_nxt     = irq_en_r;
    clr            = 2'b00;
    if (wr)
    begin
      case (idx)
        IDX_WIN_MODE:              win_mode_nxt = wbyte[2:0];
        IDX_IRQ_ENABLE:            irq_en_nxt = wbyte[1:0];
        IDX_IRQ_FLAGS,
        IDX_IRQ_CLEAR:             clr = wbyte[1:0];
        IDX_DEBUG_CTRL:            debug_ctrl_nxt = wbyte;
        IDX_RESULT,
        IDX_WIN_LOWER,
        IDX_WIN_UPPER,
        IDX_STAGING:               staging_nxt = wbyte;
        IDX_WIN_LOWER + 6'h01:     win_lower_nxt = {wbyte, staging_r};
        IDX_WIN_UPPER + 6'h01:     win_upper_nxt = {wbyte, staging_r};
        IDX_CLK_CONVERTER_CLOCK_CALIBRATION:             converter_clock_calibration_nxt = wbyte;
        default:                   clr = 2'b00;
      endcase
    end
    if (rd)
    begin
      case (idx)
        IDX_RESULT:
        begin
          staging_nxt = acc.result[15:8];
          clr         = 2'b11;
        end
        IDX_WIN_LOWER:             staging_nxt = win_lower_r[15:8];
        IDX_WIN_UPPER:             staging_nxt = win_upper_r[15:8];
        default:                   clr = 2'b00;
      endcase
    end
    // A completion in the clearing cycle keeps its flag set.
    flags_nxt[BIT_FLAG_READY] = acc.done || (flags_r[BIT_FLAG_READY] && !clr[BIT_FLAG_READY]);
    flags_nxt[BIT_FLAG_MATCH] = acc.match || (flags_r[BIT_FLAG_MATCH] && !clr[BIT_FLAG_MATCH]);
    evt_nxt  = EVENT_IN && !halted;
    halt_nxt = halted;
  end

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      debug_ctrl_r <= RST_DEBUG_CTRL;
      staging_r    <= RST_STAGING;
      win_lower_r  <= RST_WIN_LIMIT;
      win_upper_r  <= RST_WIN_LIMIT;
      converter_clock_calibration_r      <= RST_CLK_CONVERTER_CLOCK_CALIBRATION;
      win_mode_r   <= RST_WIN_MODE;
      irq_en_r     <= 2'b00;
      flags_r      <= 2'b00;
      PRDATA       <= 32'h0000_0000;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      EVENT_ACCEPT <= 1'b0;
      CONV_HALT    <= 1'b0;
      CLK_DUTY_25  <= 1'b1;
      RESULT_READY <= 1'b0;
      WINDOW_MATCH <= 1'b0;
      IRQ          <= 1'b0;
    end
    else
    begin
      debug_ctrl_r <= debug_ctrl_nxt;
      staging_r    <= staging_nxt;
      win_lower_r  <= win_lower_nxt;
      win_upper_r  <= win_upper_nxt;
      converter_clock_calibration_r      <= converter_clock_calibration_nxt;
      win_mode_r   <= win_mode_nxt;
      irq_en_r     <= irq_en_nxt;
      flags_r      <= flags_nxt;
      PRDATA       <= prdata_nxt;
      PREADY       <= pready_nxt;
      PSLVERR      <= pslverr_nxt;
      EVENT_ACCEPT <= evt_nxt;
      CONV_HALT    <= halt_nxt;
      CLK_DUTY_25  <= converter_clock_calibration_nxt[BIT_CLK_DUTY];
      RESULT_READY <= flags_nxt[BIT_FLAG_READY];
      WINDOW_MATCH <= flags_nxt[BIT_FLAG_MATCH];
      IRQ          <= |(flags_nxt & irq_en_nxt);
    end
  end
endmodule

// ===== sim/adc_regs_assertions.sv
// Purpose: Concurrent checks on the ports of the register block.
// Assumes: One clock; RST_B low disables every check.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module adc_regs_assertions
  import adc_win_pkg::*;
(
  input wire logic              REF_CLK,
  input wire logic              RST_B,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              SAMPLE_VALID,
  input wire logic              SAMPLE_LAST,
  input wire logic              DEBUG_HALT,
  input wire logic              EVENT_IN,
  input wire logic              EVENT_ACCEPT,
  input wire logic              CONV_HALT,
  input wire logic              CLK_DUTY_25,
  input wire logic              RESULT_READY,
  input wire logic              WINDOW_MATCH,
  input wire logic              IRQ
);
  logic last_s;
  logic clear_rd;
  logic duty_wr;
  assign last_s   = SAMPLE_VALID && SAMPLE_LAST;
  assign clear_rd = PSEL && PENABLE && PREADY && !PWRITE && PADDR == {IDX_RESULT, 2'b00};
  assign duty_wr  = PSEL && PENABLE && PWRITE && PADDR == {IDX_CLK_CONVERTER_CLOCK_CALIBRATION, 2'b00};
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  AST_ONE_WAIT: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("access phase length wrong");
  AST_ERR_ZERO: assert property (PSLVERR |-> PREADY && PRDATA == 32'h00000000)
    else $error("error response malformed");
  AST_BYTE_DATA: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
    else $error("read data above the byte not zero");
  AST_HALT_CAUSE: assert property (CONV_HALT |-> $past(DEBUG_HALT))
    else $error("halt without debug halt");
  AST_EVENT_PASS: assert property (EVENT_ACCEPT |-> $past(EVENT_IN) && !CONV_HALT)
    else $error("event passed without cause or while halted");
  AST_READY_SET: assert property (last_s && !DEBUG_HALT |-> ##2 RESULT_READY)
    else $error("ready flag late");
  AST_READ_CLEAR: assert property (clear_rd && !$past(last_s) && !$past(last_s, 2)
    |=> !RESULT_READY && !WINDOW_MATCH)
    else $error("result read did not clear flags");
  AST_MATCH_FLAG: assert property ($rose(WINDOW_MATCH) |-> RESULT_READY)
    else $error("match without result");
  AST_IRQ_SOURCE: assert property (!RESULT_READY && !WINDOW_MATCH
    && $past(!RESULT_READY && !WINDOW_MATCH) |-> !IRQ)
    else $error("interrupt without flag");
  AST_DUTY_WRITE: assert property ($changed(CLK_DUTY_25)
    |-> $past(duty_wr) || $past(duty_wr, 2))
    else $error("duty changed without write");
endmodule
bind adc_result_window_regs adc_regs_assertions chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_LAST(SAMPLE_LAST), .DEBUG_HALT(DEBUG_HALT),
  .EVENT_IN(EVENT_IN), .EVENT_ACCEPT(EVENT_ACCEPT), .CONV_HALT(CONV_HALT),
  .CLK_DUTY_25(CLK_DUTY_25), .RESULT_READY(RESULT_READY), .WINDOW_MATCH(WINDOW_MATCH),
  .IRQ(IRQ));

// ===== sim/apb_host_model.sv
// Purpose: Processor-side APB master that issues register accesses.
// Assumes: One transfer at a time, started by a call to xfer.
// Notes:   Signals change just after a rising edge and hold until ready is seen.
`timescale 1ns/1ps
module apb_host_model
  import adc_win_pkg::*;
(
  input  wire logic              clk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [DATA_W-1:0] pwdata,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  initial
  begin
    {psel, penable, pwrite} = 3'b000;
    paddr = '0;
    pwdata = '0;
  end
  task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
                      output logic [7:0] rd, output logic err);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the bench watchdog ends a wait for ready.
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== sim/tb_adc_result_window_regs.sv
// Purpose: Self-checking bench for the converter result and window registers.
// Assumes: 25 MHz clock; every register access goes through the host model.
// Notes:   Random data come from an xorshift generator with a fixed seed.
`timescale 1ns/1ps
module tb_adc_result_window_regs
  import adc_win_pkg::*;
;
  logic              ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              s_valid, s_over, s_under, s_last, dbg_halt, ev_in;
  logic              ev_acc, conv_halt, duty25, res_rdy, win_hit, irq;
  logic [9:0]        s_data;
  logic [31:0]       seed = 32'h0000E9C1;
  logic [15:0]       exp_sum, v, lo, hi;
  logic [7:0]        rd;
  logic [5:0]        ridx [9] = '{IDX_DEBUG_CTRL, IDX_STAGING, IDX_WIN_LOWER, 6'h13,
                                  IDX_WIN_UPPER, 6'h15, IDX_CLK_CONVERTER_CLOCK_CALIBRATION, IDX_RESULT, 6'h11};
  int                error_cnt = 0;
  int                cmp_count = 0;
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  adc_result_window_regs uut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SAMPLE_VALID(s_valid), .SAMPLE_DATA(s_data), .SAMPLE_OVER(s_over),
    .SAMPLE_UNDER(s_under), .SAMPLE_LAST(s_last), .DEBUG_HALT(dbg_halt), .EVENT_IN(ev_in),
    .EVENT_ACCEPT(ev_acc), .CONV_HALT(conv_halt), .CLK_DUTY_25(duty25),
    .RESULT_READY(res_rdy), .WINDOW_MATCH(win_hit), .IRQ(irq));
  apb_host_model host (
    .clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic win_exp(input logic [2:0] m, input logic [15:0] r, l, h);
    case (m)
      WIN_BELOW:   return r < l;
      WIN_ABOVE:   return r > h;
      WIN_INSIDE:  return r > l && r < h;
      WIN_OUTSIDE: return r < l || r > h;
      default:     return 1'b0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    host.xfer(1'b1, i, d, rd, err);
  endtask
  task automatic rd8(input logic [5:0] i);
    host.xfer(1'b0, i, 8'h00, rd, err);
  endtask
  task automatic wr16(input logic [5:0] i, input logic [15:0] d);
    wr(i, d[7:0]);
    wr(i + 6'h01, d[15:8]);
  endtask
  task automatic rd16(input logic [5:0] i);
    rd8(i);
    v[7:0] = rd;
    rd8(i + 6'h01);
    v[15:8] = rd;
  endtask
  // Kind 0 mixes random, over- and under-range samples; 1 is all over, 2 all under.
  task automatic burst(input int n, input int kind);
    logic o, u;
    exp_sum = 16'h0000;
    @(posedge ref_clk);
    for (int k = 0; k < n; k++)
    begin
      seed = xs(seed);
      o = kind == 1 || (kind == 0 && seed[15:12] == 4'h0);
      u = kind == 2 || (kind == 0 && seed[15:12] == 4'h1);
      exp_sum = exp_sum + (o ? 16'h03FF : u ? 16'h0000 : {6'h00, seed[9:0]});
      {s_valid, s_over, s_under, s_last} <= {1'b1, o, u, k == n - 1};
      s_data <= seed[9:0];
      @(posedge ref_clk);
    end
    {s_valid, s_last} <= 2'b00;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic evt(input logic [2:0] exp);
    @(posedge ref_clk);
    ev_in <= 1'b1;
    @(posedge ref_clk);
    ev_in <= 1'b0;
    @(negedge ref_clk);
    chk({ev_acc, conv_halt, res_rdy}, exp);
  endtask
  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
  initial
  begin
    rst_b = 1'b0;
    {s_valid, s_over, s_under, s_last, dbg_halt, ev_in} = 6'h00;
    s_data = 10'h000;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 9; i++)
    begin
      rd8(ridx[i]);
      chk(rd, i == 6 ? RST_CLK_CONVERTER_CLOCK_CALIBRATION : 8'h00);
    end
    rd8(6'h3F);
    chk({err, rd}, 9'h100);
    wr(IDX_WIN_LOWER, 8'hA5);
    wr(IDX_STAGING, 8'h3C);
    wr(IDX_WIN_LOWER + 6'h01, 8'h12);
    rd16(IDX_WIN_LOWER);
    chk(v, 16'h123C);
    rd8(IDX_STAGING);
    chk(rd, 8'h12);
    seed = xs(seed);
    lo = {4'h0, seed[11:0]};
    hi = lo + 16'h0400;
    wr16(IDX_WIN_LOWER, lo);
    wr16(IDX_WIN_UPPER, hi);
    rd16(IDX_WIN_UPPER);
    chk(v, hi);
    wr(IDX_IRQ_ENABLE, 8'h01);
    for (int m = 0; m < 12; m++)
    begin
      wr(IDX_WIN_MODE, {5'h00, m[2:0]});
      burst(1 + m, 0);
      @(negedge ref_clk);
      chk({irq, res_rdy, win_hit}, {2'b11, win_exp(m[2:0], exp_sum, lo, hi)});
      rd16(IDX_RESULT);
      chk(v, exp_sum);
      @(negedge ref_clk);
      chk({res_rdy, win_hit}, 2'b00);
    end
    burst(MAX_ACCUM, 1);
    rd16(IDX_RESULT);
    chk(v, 16'hFFC0);
    wr(IDX_IRQ_ENABLE, 8'h02);
    burst(3, 2);
    @(negedge ref_clk);
    chk({irq, res_rdy, win_hit}, 3'b010);
    rd8(IDX_IRQ_FLAGS);
    chk(rd, 8'h01);
    wr(IDX_IRQ_CLEAR, 8'h03);
    repeat (2) @(negedge ref_clk);
    chk({irq, res_rdy}, 2'b00);
    wr(IDX_RESULT + 6'h01, 8'hFF);
    rd16(IDX_RESULT);
    chk(v, 16'h0000);
    wr(IDX_DEBUG_CTRL, 8'h00);
    dbg_halt <= 1'b1;
    burst(2, 1);
    evt(3'b010);
    wr(IDX_DEBUG_CTRL, 8'h01);
    burst(2, 1);
    evt(3'b101);
    rd16(IDX_RESULT);
    chk(v, 16'h07FE);
    dbg_halt <= 1'b0;
    wr(IDX_CLK_CONVERTER_CLOCK_CALIBRATION, 8'h00); // 50 percent duty for a fast converter clock
    @(negedge ref_clk);
    chk(duty25, 1'b0);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd8(IDX_CLK_CONVERTER_CLOCK_CALIBRATION);
    chk({duty25, rd}, 9'h101);
    stop_test();
  end
endmodule
